// *** logic/dcc_defines.svh ***
// register offsets, field positions, reset values and fixed counts of the
// dma channel control block; assumes an 8-bit special function register bus
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define DCC_OFS_DONE_FLAGS     8'hD1
`define DCC_OFS_CH1TO4_PTR_LO  8'hD2
`define DCC_OFS_CH1TO4_PTR_HI  8'hD3
`define DCC_OFS_CH0_PTR_LO     8'hD4
`define DCC_OFS_CH0_PTR_HI     8'hD5
`define DCC_OFS_CHANNEL_ARMING 8'hD6
`define DCC_OFS_MANUAL_REQUEST 8'hD7

// ----------------------------------------------------------------------
// fields, reset values and sizes
// ----------------------------------------------------------------------
`define DCC_NUM_CH             5
`define DCC_ABORT_BIT          7
`define DCC_PTR_RESET          8'h00
`define DCC_MASK_RESET         5'h00
`define DCC_DESC_STRIDE        16'h0008
`define DCC_FIFO_DEPTH         16

`endif

// *** logic/dcc_pkg.sv ***
// types shared by the dma channel control block and its request queue
// assumes dcc_defines.svh is on the include path
`include "dcc_defines.svh"

package dcc_pkg;
   // one bit per channel
   typedef logic [`DCC_NUM_CH-1:0] dcc_chmask_t;
   // channel number
   typedef logic [2:0]             dcc_chan_t;
   // descriptor address in memory
   typedef logic [15:0]            dcc_addr_t;
   // arbitration priority against the cpu, in field encoding order
   typedef enum logic [1:0] {
      DCC_PRIO_LOW,
      DCC_PRIO_NORMAL,
      DCC_PRIO_HIGH,
      DCC_PRIO_RESERVED
   } dcc_prio_t;
endpackage : dcc_pkg

// *** logic/dcc_queue_if.sv ***
// carrier between the control block and its granted-request queue
// assumes both ends share one clock
`timescale 1ns/1ps

interface dcc_queue_if #(parameter int WIDTH = 19);
   logic             push_valid;
   logic             push_ready;
   logic [WIDTH-1:0] push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [WIDTH-1:0] pop_data;

   modport fifo (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface : dcc_queue_if

// *** logic/dcc_fifo.sv ***
// small fifo with a registered output word, valid and ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module dcc_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16
) (
   input  wire logic  clk_in,
   input  wire logic  srst_in,
   dcc_queue_if.fifo  q
);
   import dcc_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [WIDTH-1:0] out_data;
   logic             out_valid;
   logic             do_push;
   logic             do_load;

   // ----------------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------------
   assign q.push_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign do_push      = q.push_valid & q.push_ready;
   assign do_load      = (count != '0) & (~out_valid | q.pop_ready);
   assign q.pop_valid  = out_valid;
   assign q.pop_data   = out_data;

   // storage write
   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem[wr_ptr] <= q.push_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (do_load) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(do_push) - (AW+1)'(do_load);
      end
   end

   // output register, read data leave from a flop
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (do_load) begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end else if (q.pop_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : dcc_fifo

// *** logic/dcc_regs.sv ***
// dma channel control and status registers with cpu memory arbitration
// assumes an 8-bit sfr bus with one-cycle write and read strobes, a transfer
// engine that reports count reached per channel and pops granted requests
// and that passes in the priority and interrupt enable read from each descriptor
`timescale 1ns/1ps
`include "dcc_defines.svh"

module dcc_regs #(
   parameter int NUM_CH     = `DCC_NUM_CH,
   parameter int FIFO_DEPTH = `DCC_FIFO_DEPTH
) (
   input  wire logic              CLK_IN,
   input  wire logic              SRST_IN,
   // special function register bus
   input  wire logic [7:0]        SFR_ADDR_IN,
   input  wire logic              SFR_WR_IN,
   input  wire logic              SFR_RD_IN,
   input  wire logic [7:0]        SFR_WDATA_IN,
   output logic      [7:0]        SFR_RDATA_OUT,
   // transfer engine status per channel
   input  wire dcc_pkg::dcc_chmask_t TRIG_IN,
   input  wire dcc_pkg::dcc_chmask_t COUNT_DONE_IN,
   input  wire dcc_pkg::dcc_chmask_t REPEAT_MODE_IN,
   input  wire dcc_pkg::dcc_chmask_t IRQ_EN_IN,
   input  wire logic [2*`DCC_NUM_CH-1:0] PRIORITY_IN,
   // memory arbitration against the cpu
   input  wire logic              CPU_MEM_REQ_IN,
   output logic                   CPU_GRANT_OUT,
   output dcc_pkg::dcc_chmask_t   CH_GRANT_OUT,
   // channel state
   output dcc_pkg::dcc_chmask_t   CH_ARMED_OUT,
   output dcc_pkg::dcc_chmask_t   CH_ABORT_OUT,
   output logic                   DONE_IRQ_OUT,
   // granted requests towards the transfer engine
   output logic                   XFER_VALID_OUT,
   input  wire logic              XFER_READY_IN,
   output dcc_pkg::dcc_chan_t     XFER_CHAN_OUT,
   output dcc_pkg::dcc_addr_t     XFER_DESC_OUT
);
   import dcc_pkg::*;

   localparam int QW = 19;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   dcc_chmask_t arm;
   dcc_chmask_t manual_trigger;
   dcc_chmask_t hw_pend;
   dcc_chmask_t done_flag;
   dcc_chmask_t lost_last;
   dcc_chmask_t abort_pulse;
   logic [7:0]  ch0_ptr_lo;
   logic [7:0]  ch0_ptr_hi;
   logic [7:0]  ch14_ptr_lo;
   logic [7:0]  ch14_ptr_hi;
   logic        irq;
   logic [7:0]  rdata;
   logic [7:0]  next_rdata;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic        wr_arm;
   logic        wr_req;
   logic        wr_done;
   logic        abort_wr;
   dcc_chmask_t wr_mask;

   // one strobe per written register
   // bits 6 and 5 of an arm write are ignored, bit 7 turns the write into an abort
   assign wr_arm   = SFR_WR_IN & (SFR_ADDR_IN == `DCC_OFS_CHANNEL_ARMING);
   assign wr_req   = SFR_WR_IN & (SFR_ADDR_IN == `DCC_OFS_MANUAL_REQUEST);
   assign wr_done  = SFR_WR_IN & (SFR_ADDR_IN == `DCC_OFS_DONE_FLAGS);
   assign wr_mask  = SFR_WDATA_IN[NUM_CH-1:0];
   assign abort_wr = wr_arm & SFR_WDATA_IN[`DCC_ABORT_BIT];

   // ----------------------------------------------------------------------
   // arbitration
   // ----------------------------------------------------------------------
   dcc_chmask_t request;
   dcc_chmask_t grant;
   dcc_chan_t   sel;
   logic        any_req;
   logic        dma_wins;
   dcc_prio_t   sel_prio;
   dcc_addr_t   sel_desc;
   dcc_addr_t   ch0_ptr;
   dcc_addr_t   ch14_ptr;
   logic        q_ready;

   dcc_queue_if #(.WIDTH(QW)) q ();

   assign ch0_ptr  = {ch0_ptr_hi, ch0_ptr_lo};
   assign ch14_ptr = {ch14_ptr_hi, ch14_ptr_lo};

   // a channel asks for memory only while armed and triggered
   // a trigger that arrives while unarmed stays pending and is served once armed
   assign request = arm & (manual_trigger | hw_pend);

   // lowest numbered requesting channel is served first
   always_comb begin
      sel     = '0;
      any_req = 1'b0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (request[i]) begin
            sel     = dcc_chan_t'(i);
            any_req = 1'b1;
         end
      end
   end

   assign sel_prio = dcc_prio_t'(PRIORITY_IN[2*sel +: 2]);

   // priority against the cpu; reserved code is treated as low
   // a full queue blocks the dma side entirely, so the cpu then always gets memory
   always_comb begin
      dma_wins = 1'b0;
      if (any_req && q_ready) begin
         if (!CPU_MEM_REQ_IN) begin
            dma_wins = 1'b1;
         end else begin
            case (sel_prio)
               DCC_PRIO_HIGH:   dma_wins = 1'b1;
               DCC_PRIO_NORMAL: dma_wins = lost_last[sel];
               DCC_PRIO_LOW:    dma_wins = 1'b0;
               default:         dma_wins = 1'b0;
            endcase
         end
      end
   end

   // descriptor of the chosen channel
   // channel 1 to 4 descriptors are taken as contiguous, so no extra pointer
   // registers are needed; a wrong base address silently shifts all four
   always_comb begin
      if (sel == '0) begin
         sel_desc = ch0_ptr;
      end else begin
         sel_desc = ch14_ptr + dcc_addr_t'(({13'h0000, sel} - 16'h0001) * `DCC_DESC_STRIDE);
      end
   end

   assign grant         = dma_wins ? dcc_chmask_t'(1 << sel) : '0;
   assign CH_GRANT_OUT  = grant;
   assign CPU_GRANT_OUT = CPU_MEM_REQ_IN & ~dma_wins;

   // every other try for a normal channel the cpu must step aside
   // a loss is only remembered while the queue can accept, so a full queue
   // does not bank a free win for the channel
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         lost_last <= `DCC_MASK_RESET;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (grant[i]) begin
               lost_last[i] <= 1'b0;
            end else if (any_req && q_ready && sel == dcc_chan_t'(i)) begin
               lost_last[i] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // arming and abort
   // ----------------------------------------------------------------------
   // abort beats a plain arm write, and any arm write beats the count-reached
   // clear, so a count event in the cycle of an arm write does not undo that write
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         arm <= `DCC_MASK_RESET;
      end else if (abort_wr) begin
         arm <= arm & ~wr_mask;
      end else if (wr_arm) begin
         arm <= wr_mask;
      end else begin
         arm <= arm & ~(COUNT_DONE_IN & ~REPEAT_MODE_IN);
      end
   end

   // abort strobe to the engine, only for the channels named
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         abort_pulse <= `DCC_MASK_RESET;
      end else begin
         abort_pulse <= abort_wr ? wr_mask : '0;
      end
   end

   // ----------------------------------------------------------------------
   // triggers
   // ----------------------------------------------------------------------
   // software trigger: set wins over the clear on grant
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         manual_trigger <= `DCC_MASK_RESET;
      end else begin
         manual_trigger <= (manual_trigger & ~grant)
                         | (wr_req ? wr_mask : '0);
      end
   end

   // hardware trigger pending until served or aborted
   // repeated triggers merge while one is pending; the engine sees one request
   // per grant, never a backlog
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         hw_pend <= `DCC_MASK_RESET;
      end else begin
         hw_pend <= (hw_pend & ~grant & ~(abort_wr ? wr_mask : '0)) | TRIG_IN;
      end
   end

   // ----------------------------------------------------------------------
   // done flags and interrupt
   // ----------------------------------------------------------------------
   // a count event in the clearing cycle keeps the flag set
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         done_flag <= `DCC_MASK_RESET;
      end else begin
         done_flag <= (wr_done ? (done_flag & wr_mask) : done_flag)
                    | COUNT_DONE_IN;
      end
   end

   // interrupt request pulse gated by the descriptor enable
   // the pulse does not depend on the done flags, so clearing a flag never
   // raises or drops an interrupt
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         irq <= 1'b0;
      end else begin
         irq <= |(COUNT_DONE_IN & IRQ_EN_IN);
      end
   end

   // ----------------------------------------------------------------------
   // descriptor pointers
   // ----------------------------------------------------------------------
   // the two bytes of a pointer are separate registers with no latching; write
   // both before arming a channel, a half-updated pointer is used as it stands
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         ch0_ptr_lo <= `DCC_PTR_RESET;
         ch0_ptr_hi <= `DCC_PTR_RESET;
      end else if (SFR_WR_IN) begin
         if (SFR_ADDR_IN == `DCC_OFS_CH0_PTR_LO) begin
            ch0_ptr_lo <= SFR_WDATA_IN;
         end
         if (SFR_ADDR_IN == `DCC_OFS_CH0_PTR_HI) begin
            ch0_ptr_hi <= SFR_WDATA_IN;
         end
      end
   end

   // shared base of the channel 1 to 4 descriptors
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         ch14_ptr_lo <= `DCC_PTR_RESET;
         ch14_ptr_hi <= `DCC_PTR_RESET;
      end else if (SFR_WR_IN) begin
         if (SFR_ADDR_IN == `DCC_OFS_CH1TO4_PTR_LO) begin
            ch14_ptr_lo <= SFR_WDATA_IN;
         end
         if (SFR_ADDR_IN == `DCC_OFS_CH1TO4_PTR_HI) begin
            ch14_ptr_hi <= SFR_WDATA_IN;
         end
      end
   end

   // ----------------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------------
   // read multiplexer, unused bits and unmapped offsets read zero
   always_comb begin
      case (SFR_ADDR_IN)
         `DCC_OFS_DONE_FLAGS:     next_rdata = {3'h0, done_flag};
         `DCC_OFS_CH1TO4_PTR_LO:  next_rdata = ch14_ptr_lo;
         `DCC_OFS_CH1TO4_PTR_HI:  next_rdata = ch14_ptr_hi;
         `DCC_OFS_CH0_PTR_LO:     next_rdata = ch0_ptr_lo;
         `DCC_OFS_CH0_PTR_HI:     next_rdata = ch0_ptr_hi;
         `DCC_OFS_CHANNEL_ARMING: next_rdata = {3'h0, arm};
         `DCC_OFS_MANUAL_REQUEST: next_rdata = {3'h0, manual_trigger};
         default:                 next_rdata = 8'h00;
      endcase
   end

   // registered read data, held until the next read strobe
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         rdata <= 8'h00;
      end else if (SFR_RD_IN) begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // granted request queue
   // ----------------------------------------------------------------------
   // a full queue stalls arbitration so no grant is lost
   assign q.push_valid = dma_wins;
   assign q.push_data  = {sel, sel_desc};
   assign q.pop_ready  = XFER_READY_IN;
   assign q_ready      = q.push_ready;

   dcc_fifo #(
      .WIDTH (QW),
      .DEPTH (FIFO_DEPTH)
   ) u_queue (
      .clk_in  (CLK_IN),
      .srst_in (SRST_IN),
      .q       (q)
   );

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign SFR_RDATA_OUT  = rdata;
   assign CH_ARMED_OUT   = arm;
   assign CH_ABORT_OUT   = abort_pulse;
   assign DONE_IRQ_OUT   = irq;
   assign XFER_VALID_OUT = q.pop_valid;
   assign XFER_CHAN_OUT  = q.pop_data[18:16];
   assign XFER_DESC_OUT  = q.pop_data[15:0];
endmodule : dcc_regs

// *** bench/dcc_regs_asserts.sv ***
// port-level checks of the dma channel control block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module dcc_regs_asserts #(
   parameter int NUM_CH     = 5,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic                 CLK_IN,
   input wire logic                 SRST_IN,
   input wire logic [7:0]           SFR_ADDR_IN,
   input wire logic                 SFR_WR_IN,
   input wire logic                 SFR_RD_IN,
   input wire logic [7:0]           SFR_WDATA_IN,
   input wire logic [7:0]           SFR_RDATA_OUT,
   input wire dcc_pkg::dcc_chmask_t COUNT_DONE_IN,
   input wire dcc_pkg::dcc_chmask_t REPEAT_MODE_IN,
   input wire dcc_pkg::dcc_chmask_t IRQ_EN_IN,
   input wire logic [9:0]           PRIORITY_IN,
   input wire logic                 CPU_MEM_REQ_IN,
   input wire logic                 CPU_GRANT_OUT,
   input wire dcc_pkg::dcc_chmask_t CH_GRANT_OUT,
   input wire dcc_pkg::dcc_chmask_t CH_ARMED_OUT,
   input wire dcc_pkg::dcc_chmask_t CH_ABORT_OUT,
   input wire logic                 DONE_IRQ_OUT,
   input wire logic                 XFER_VALID_OUT
);
   import dcc_pkg::*;
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   logic irq_cause;
   logic low_grant;
   logic arm_write;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SRST_IN);
   // write to the arm register
   assign arm_write = SFR_WR_IN && (SFR_ADDR_IN == 8'hD6);
   // an enabled count-reached event seen at the last edge
   always_ff @(posedge CLK_IN) begin
      irq_cause <= !SRST_IN && |(COUNT_DONE_IN & IRQ_EN_IN);
   end
   // grant given to a channel whose priority is low or reserved
   always_comb begin
      low_grant = 1'b0;
      for (int n = 0; n < NUM_CH; n++) begin
         low_grant = low_grant | (CH_GRANT_OUT[n] && (PRIORITY_IN[2*n+1] == PRIORITY_IN[2*n]));
      end
   end
   sequence abort_write_s;
      arm_write && SFR_WDATA_IN[7];
   endsequence
   sequence fresh_grant_s;
      (CH_GRANT_OUT != '0) && !XFER_VALID_OUT;
   endsequence
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   abort_reads_zero_a: assert property (
      SFR_RD_IN && SFR_ADDR_IN == 8'hD6 |=> SFR_RDATA_OUT[7:5] == 3'h0)
      else $error("arm register upper bits read nonzero");
   abort_disarm_a: assert property (
      abort_write_s |=> (CH_ARMED_OUT & $past(SFR_WDATA_IN[4:0])) == '0)
      else $error("aborted channel still armed");
   abort_pulse_a: assert property (
      abort_write_s |=> CH_ABORT_OUT == $past(SFR_WDATA_IN[4:0]))
      else $error("abort pulse names the wrong channels");
   arm_load_a: assert property (
      arm_write && !SFR_WDATA_IN[7] && COUNT_DONE_IN == '0
      |=> CH_ARMED_OUT == $past(SFR_WDATA_IN[4:0]))
      else $error("arm bits not loaded from write data");
   grant_armed_a: assert property (
      $onehot0(CH_GRANT_OUT) && (CH_GRANT_OUT & ~CH_ARMED_OUT) == '0)
      else $error("grant to an unarmed channel or to several");
   auto_disarm_a: assert property (
      !arm_write |=> (CH_ARMED_OUT & $past(COUNT_DONE_IN) & ~$past(REPEAT_MODE_IN)) == '0)
      else $error("one-shot channel still armed after count reached");
   queue_entry_a: assert property (
      fresh_grant_s |-> ##2 XFER_VALID_OUT)
      else $error("granted request did not reach the queue head");
   irq_follow_a: assert property (
      DONE_IRQ_OUT == irq_cause)
      else $error("interrupt pulse does not follow enabled count events");
   low_defer_a: assert property (
      CPU_MEM_REQ_IN |-> !low_grant)
      else $error("low priority channel beat the cpu");
   cpu_grant_a: assert property (
      CPU_GRANT_OUT == (CPU_MEM_REQ_IN && CH_GRANT_OUT == '0))
      else $error("cpu grant inconsistent with dma grant");
endmodule : dcc_regs_asserts

bind dcc_regs dcc_regs_asserts #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) chk (
   .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .SFR_ADDR_IN(SFR_ADDR_IN),
   .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
   .SFR_RDATA_OUT(SFR_RDATA_OUT), .COUNT_DONE_IN(COUNT_DONE_IN),
   .REPEAT_MODE_IN(REPEAT_MODE_IN), .IRQ_EN_IN(IRQ_EN_IN), .PRIORITY_IN(PRIORITY_IN),
   .CPU_MEM_REQ_IN(CPU_MEM_REQ_IN), .CPU_GRANT_OUT(CPU_GRANT_OUT),
   .CH_GRANT_OUT(CH_GRANT_OUT), .CH_ARMED_OUT(CH_ARMED_OUT),
   .CH_ABORT_OUT(CH_ABORT_OUT), .DONE_IRQ_OUT(DONE_IRQ_OUT),
   .XFER_VALID_OUT(XFER_VALID_OUT));

// *** bench/dcc_engine_model.sv ***
// transfer engine model that pops granted requests off the queue head
// assumes an entry is taken at a rising edge with valid and ready high
`timescale 1ns/1ps

module dcc_engine_model (
   input  wire logic               clk_in,
   input  wire logic               stall_in,
   input  wire logic               valid_in,
   input  wire dcc_pkg::dcc_chan_t chan_in,
   input  wire dcc_pkg::dcc_addr_t desc_in,
   output logic                    ready_out
);
   import dcc_pkg::*;
   logic [18:0] popped [$];
   // ready drops while the engine is busy elsewhere
   assign ready_out = !stall_in;
   // record each entry at the edge that takes it
   always @(posedge clk_in) begin
      if (valid_in && ready_out) popped.push_back({chan_in, desc_in});
   end
endmodule : dcc_engine_model

// *** bench/tb.sv ***
// self-checking bench of the dma channel control block
// assumes the engine model and the port checker are compiled beforehand
`timescale 1ns/1ps

module tb;
   import dcc_pkg::*;
   typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} dcc_row_t;
   localparam dcc_row_t ROWS [17] = '{
      '{1'b0, 8'hD1, 8'h00, 8'h00}, '{1'b0, 8'hD2, 8'h00, 8'h00}, '{1'b0, 8'hD3, 8'h00, 8'h00},
      '{1'b0, 8'hD4, 8'h00, 8'h00}, '{1'b0, 8'hD5, 8'h00, 8'h00}, '{1'b0, 8'hD6, 8'h00, 8'h00},
      '{1'b0, 8'hD7, 8'h00, 8'h00}, '{1'b1, 8'hD4, 8'hA5, 8'hA5}, '{1'b1, 8'hD5, 8'h3C, 8'h3C},
      '{1'b1, 8'hD2, 8'h5A, 8'h5A}, '{1'b1, 8'hD3, 8'hC3, 8'hC3}, '{1'b1, 8'hD6, 8'h1F, 8'h1F},
      '{1'b1, 8'hD6, 8'h83, 8'h1C}, '{1'b1, 8'hD6, 8'hE0, 8'h1C}, '{1'b1, 8'hD6, 8'h00, 8'h00},
      '{1'b1, 8'hD0, 8'h55, 8'h00}, '{1'b1, 8'hD1, 8'h1F, 8'h00}};
   localparam logic [1:0] PRIO [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
   localparam logic       WIN  [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic clk, srst, sfr_wr, sfr_rd, cpu_req, cpu_grant, irq, xfer_valid, xfer_ready, stall, got;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
   logic [9:0]  prio;
   dcc_chmask_t trig, count_done, repeat_mode, irq_en, ch_grant, armed, abort;
   dcc_chan_t   xfer_chan;
   dcc_addr_t   xfer_desc;
   int          fail_count, samples_checked;

   dcc_regs uut (.CLK_IN(clk), .SRST_IN(srst), .SFR_ADDR_IN(sfr_addr), .SFR_WR_IN(sfr_wr),
      .SFR_RD_IN(sfr_rd), .SFR_WDATA_IN(sfr_wdata), .SFR_RDATA_OUT(sfr_rdata), .TRIG_IN(trig),
      .COUNT_DONE_IN(count_done), .REPEAT_MODE_IN(repeat_mode), .IRQ_EN_IN(irq_en),
      .PRIORITY_IN(prio), .CPU_MEM_REQ_IN(cpu_req), .CPU_GRANT_OUT(cpu_grant),
      .CH_GRANT_OUT(ch_grant), .CH_ARMED_OUT(armed), .CH_ABORT_OUT(abort), .DONE_IRQ_OUT(irq),
      .XFER_VALID_OUT(xfer_valid), .XFER_READY_IN(xfer_ready), .XFER_CHAN_OUT(xfer_chan),
      .XFER_DESC_OUT(xfer_desc));
   dcc_engine_model eng (.clk_in(clk), .stall_in(stall), .valid_in(xfer_valid),
      .chan_in(xfer_chan), .desc_in(xfer_desc), .ready_out(xfer_ready));

   // ----------------------------------------------------------------
   // clock and tasks
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [18:0] g, input logic [18:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick();
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick();
      sfr_wr = 1'b0;
   endtask : wr
   task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
      tick();
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick();
      sfr_rd = 1'b0;
      tick();
      check(19'(sfr_rdata), 19'(e));
   endtask : chkrd
   // waits a bounded time for the engine to take the next entry
   task automatic cmp_entry(input logic [18:0] e);
      int n;
      n = 0;
      while (eng.popped.size() == 0 && n < 60) begin
         tick();
         n++;
      end
      if (eng.popped.size() == 0) begin
         fail_count++;
         $display("Error at %0t: got none expected %h", $time, e);
         summarize();
      end else begin
         check(eng.popped.pop_front(), e);
      end
   endtask : cmp_entry

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {srst, sfr_wr, sfr_rd, cpu_req, stall, sfr_addr, sfr_wdata, prio} = '0;
      {trig, count_done, repeat_mode, irq_en} = '0;
      fail_count = 0;
      samples_checked = 0;
      srst = 1'b1;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
         chkrd(ROWS[i].a, ROWS[i].e);
      end
      // manual requests, one of them waiting for its arm bit
      wr(8'hD7, 8'h02);
      chkrd(8'hD7, 8'h02);
      wr(8'hD6, 8'h07);
      wr(8'hD7, 8'h05);
      cmp_entry({3'h1, 16'hC35A});
      cmp_entry({3'h0, 16'h3CA5});
      cmp_entry({3'h2, 16'hC362});
      chkrd(8'hD7, 8'h00);
      // count reached, channel 1 repeating, only channel 0 raising an interrupt
      repeat_mode = 5'h02;
      irq_en = 5'h01;
      count_done = 5'h03;
      tick();
      count_done = 5'h04;
      check(19'(irq), 19'h0_0001);
      tick();
      count_done = 5'h00;
      check(19'(irq), 19'h0_0000);
      chkrd(8'hD6, 8'h02);
      chkrd(8'hD1, 8'h07);
      wr(8'hD1, 8'h1A);
      chkrd(8'hD1, 8'h02);
      // every priority code against a busy cpu
      wr(8'hD6, 8'h08);
      cpu_req = 1'b1;
      foreach (PRIO[i]) begin
         prio = {2'h0, PRIO[i], 6'h00};
         wr(8'hD7, 8'h08);
         got = 1'b0;
         repeat (6) begin
            got = got | ch_grant[3];
            tick();
         end
         check(19'(got), 19'(WIN[i]));
      end
      cpu_req = 1'b0;
      repeat (3) cmp_entry({3'h3, 16'hC36A});
      // fill the queue with hardware triggers while the engine stalls
      prio = 10'h000;
      stall = 1'b1;
      wr(8'hD6, 8'h10);
      repeat (20) begin
         tick();
         trig = 5'h10;
         tick();
         trig = 5'h00;
      end
      check(19'(eng.popped.size()), 19'h0_0000);
      stall = 1'b0;
      repeat (18) cmp_entry({3'h4, 16'hC372});
      repeat (6) tick();
      check(19'(xfer_valid), 19'h0_0000);
      check(19'(eng.popped.size()), 19'h0_0000);
      // a second reset in mid-run clears the arm bits and the pointers
      srst = 1'b1;
      repeat (2) tick();
      srst = 1'b0;
      check(19'(armed), 19'h0_0000);
      chkrd(8'hD5, 8'h00);
      chkrd(8'hD2, 8'h00);
      summarize();
   end
endmodule : tb
